// >>> rtl/alt_defs.vh
// Constants for the alarm and loopback test control block
`ifndef ALT_DEFS_VH
`define ALT_DEFS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ALT_REG_CTRL 12'h000
`define ALT_REG_FILT 12'h004
`define ALT_REG_NMSK 12'h008
`define ALT_REG_RAW 12'h00C
`define ALT_REG_ACT 12'h010
`define ALT_REG_EVT 12'h014
`define ALT_REG_LLB 12'h018
`define ALT_REG_LLBL 12'h01C
`define ALT_REG_EOC 12'h020
`define ALT_REG_DROP 12'h024
`define ALT_REG_DPORT 12'h028
`define ALT_REG_CLB 12'h02C
`define ALT_REG_TEST 12'h030
`define ALT_REG_SAVED 12'h034
`define ALT_REG_CAUSE 12'h038
// ----------------------------------------------------------------
// Severity codes
// ----------------------------------------------------------------
`define ALT_SEV_CLEARED 3'h0
`define ALT_SEV_INDET 3'h1
`define ALT_SEV_CRIT 3'h2
`define ALT_SEV_MAJOR 3'h3
`define ALT_SEV_MINOR 3'h4
`define ALT_SEV_WARN 3'h5
`define ALT_SEV_PEND 3'h6
// ----------------------------------------------------------------
// Alarm bit positions (22 alarms in a 26-bit vector)
// ----------------------------------------------------------------
`define ALT_NUM_ALM 26
`define ALT_A_U_LOS 0
`define ALT_A_U_BPV 1
`define ALT_A_S_LOS 2
`define ALT_A_S_LOF 3
`define ALT_A_S_EXBER 4
`define ALT_A_S_RDI 5
`define ALT_A_S_AIS 6
`define ALT_A_S_LMFA 7
`define ALT_A_S_RMAI 8
`define ALT_A_S_SAIS 9
`define ALT_A_MGMT 10
`define ALT_A_SYNC 11
`define ALT_A_PORT 12
`define ALT_A_PWR 13
`define ALT_A_XC 14
`define ALT_A_TIMING 15
`define ALT_A_CL 16
`define ALT_A_TMGT 17
`define ALT_A_AMEM 18
`define ALT_A_DLOAD 19
`define ALT_A_SWC 20
`define ALT_A_DB 21
// ----------------------------------------------------------------
// Timing: filter tick is 1 s; notification steps are 10 ticks
// ----------------------------------------------------------------
`define ALT_CLK_HZ 20000000
`define ALT_TICK_S 1
`define ALT_TICK_CYC (`ALT_CLK_HZ * `ALT_TICK_S)
`define ALT_TF_MAX 4'hA
`define ALT_NF_MAX 3'h6
`define ALT_NF_STEP 7'h0A
`define ALT_EVT_W 40
`endif

// >>> rtl/alt_ctrl.v
// Alarm detection, filtering, severity tagging and loopback control
// Behaviour
// - Structured port raises eight communications alarms
// - Unstructured port alarms on LOS, optional BPV
// - Every alarm passes time and notification filters
// - Time filter 0-10 s, report after longer
// - Notification filter 0-60 s, 10 s steps
// - Alarm on sync loss and management link
// - Port self-check failures flagged
// - Power alarm on external or PSU fault
// - Connection failure reported with causing unit
// - Timing alarm on primary/secondary reference loss
// - Common logic CPU, memories, power flagged
// - Processing alarms for five fault kinds
// - Every alarm tagged with a severity level
// - Pending severity never triggers a notification
// - Record holds function, type, severity, cause, time
// - Remote line loopback per port, local optional
// - Refuse line loopback on active EOC port
// - Report every active loopback on request
// - Drop function for n 1..31, management controlled
// - Monitoring drop keeps connection, broadcasts both
// - Split drop breaks connection, routes both legs
// - Restore previous connections when drop ends
// - Channel loopback managed on selected channels
`timescale 1ns/1ps
`default_nettype none
`include "alt_defs.vh"
module alt_ctrl #(
    parameter TICK_CYC = `ALT_TICK_CYC,
    parameter NPORT = 8,
    parameter NCH = 32,
    parameter UNIT_W = 8
) (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Structured port defects, pins
    input wire s_los,
    input wire s_lof,
    input wire s_exber,
    input wire s_slot0_rdi,
    input wire s_ais,
    input wire s_signalling_lmfa,
    input wire s_signalling_rdi,
    input wire s_signalling_ais,
    // Unstructured port defects, pins
    input wire u_los,
    input wire u_bpv,
    // Synchronisation and management link, pins
    input wire sync_loss,
    input wire mgmt_link_fail,
    // Port self-check faults, pins: txrx, timing, power, cl, xc
    input wire [4:0] port_fault,
    // Power: external absent, internal psu fault
    input wire ext_pwr_absent,
    input wire psu_fault,
    // Connection check and unit that caused it
    input wire conn_fail,
    input wire [UNIT_W-1:0] conn_fail_unit,
    // Timing references lost
    input wire primary_timing_reference_loss,
    input wire secondary_timing_reference_loss,
    input wire secondary_required,
    // Common logic: cpu, program mem, data mem, power
    input wire [3:0] cl_fault,
    // Processing: tmgt, amem, dload, swc, db
    input wire [4:0] proc_fault,
    // Alarm notification stream to management
    output reg evt_valid,
    output reg [`ALT_EVT_W-1:0] evt_data,
    // Test controls to the matrix
    output reg [NPORT-1:0] remote_line_loopback,
    output reg [NPORT-1:0] local_line_loopback,
    output reg drop_active,
    output reg drop_split,
    output reg [NCH-1:0] drop_chans,
    output reg [NPORT-1:0] drop_ports,
    output reg [NCH-1:0] chan_loopback,
    output reg [NCH-1:0] xc_restore,
    output reg xc_restore_stb
);
    // ------------------------------------------------------------
    // Synchronisers on defect pins
    // ------------------------------------------------------------
    localparam NRAW = 32 + UNIT_W;
    wire [NRAW-1:0] pins;
    reg [NRAW-1:0] sync1_r;   // First stage, only read by sync2
    reg [NRAW-1:0] sync2_r;   // Usable copy
    assign pins = {conn_fail_unit, secondary_required,
        primary_timing_reference_loss,
        secondary_timing_reference_loss, conn_fail, ext_pwr_absent,
        psu_fault, proc_fault, cl_fault, port_fault, mgmt_link_fail,
        sync_loss, u_bpv, u_los, s_signalling_ais, s_signalling_rdi,
        s_signalling_lmfa, s_ais, s_slot0_rdi, s_exber, s_lof, s_los};
    // Two flops before any logic looks at a pin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= {NRAW{1'b0}};
            sync2_r <= {NRAW{1'b0}};
        end else if (clk_en) begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end
    // Unpack synchronised values
    wire [7:0] s_def = sync2_r[7:0];
    wire [1:0] u_def = sync2_r[9:8];
    wire [4:0] pf = sync2_r[16:12];
    wire [3:0] clf = sync2_r[20:17];
    wire [4:0] prf = sync2_r[25:21];
    // ------------------------------------------------------------
    // Raw alarm vector
    // ------------------------------------------------------------
    wire [`ALT_NUM_ALM-1:0] raw;
    reg [31:0] ctrl_r;        // bit0 bpv enable, bit1 local lb allow
    assign raw[`ALT_A_U_LOS] = u_def[0];
    assign raw[`ALT_A_U_BPV] = u_def[1] & ctrl_r[0];
    assign raw[`ALT_A_S_LOS] = s_def[0];
    assign raw[`ALT_A_S_LOF] = s_def[1];
    assign raw[`ALT_A_S_EXBER] = s_def[2];
    assign raw[`ALT_A_S_RDI] = s_def[3];
    assign raw[`ALT_A_S_AIS] = s_def[4];
    assign raw[`ALT_A_S_LMFA] = s_def[5];
    assign raw[`ALT_A_S_RMAI] = s_def[6];
    assign raw[`ALT_A_S_SAIS] = s_def[7];
    assign raw[`ALT_A_MGMT] = sync2_r[11];
    assign raw[`ALT_A_SYNC] = sync2_r[10];
    assign raw[`ALT_A_PORT] = |pf;
    assign raw[`ALT_A_PWR] = sync2_r[27] | sync2_r[26];
    assign raw[`ALT_A_XC] = sync2_r[28];
    // Secondary counts only when the build needs it
    assign raw[`ALT_A_TIMING] = sync2_r[30] |
        (sync2_r[29] & sync2_r[31]);
    assign raw[`ALT_A_CL] = |clf;
    assign raw[`ALT_A_TMGT] = prf[0];
    assign raw[`ALT_A_AMEM] = prf[1];
    assign raw[`ALT_A_DLOAD] = prf[2];
    assign raw[`ALT_A_SWC] = prf[3];
    assign raw[`ALT_A_DB] = prf[4];
    assign raw[25:22] = 4'h0;
    // ------------------------------------------------------------
    // Severity table per alarm
    // ------------------------------------------------------------
    function [2:0] sev_of;
        input [4:0] idx;
        begin
            case (idx)
                5'd0: sev_of = `ALT_SEV_MAJOR;
                5'd1: sev_of = `ALT_SEV_PEND;
                5'd2, 5'd3, 5'd10, 5'd13, 5'd14, 5'd15:
                    sev_of = `ALT_SEV_CRIT;
                5'd4, 5'd5, 5'd6, 5'd7, 5'd8, 5'd9, 5'd17, 5'd18:
                    sev_of = `ALT_SEV_MINOR;
                5'd11, 5'd12, 5'd16, 5'd19, 5'd20, 5'd21:
                    sev_of = `ALT_SEV_MAJOR;
                default: sev_of = `ALT_SEV_INDET;
            endcase
        end
    endfunction
    // ------------------------------------------------------------
    // Second tick and filter registers
    // ------------------------------------------------------------
    reg [31:0] tick_cnt_r;
    reg tick_r;
    reg [31:0] sec_r;          // Event time in seconds
    reg [31:0] filt_r;         // [3:0] time filter s, [6:4] notif steps
    reg [`ALT_NUM_ALM-1:0] nmsk_r; // Spontaneous notification select
    wire [3:0] tf_set = (filt_r[3:0] > `ALT_TF_MAX) ?
        `ALT_TF_MAX : filt_r[3:0];
    wire [2:0] nf_set = (filt_r[6:4] > `ALT_NF_MAX) ?
        `ALT_NF_MAX : filt_r[6:4];
    wire [6:0] nf_sec = nf_set * `ALT_NF_STEP;
    // One-second tick from the bus clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= 32'h0;
            tick_r <= 1'b0;
            sec_r <= 32'h0;
        end else if (clk_en) begin
            tick_r <= (tick_cnt_r == TICK_CYC - 1);
            if (tick_cnt_r == TICK_CYC - 1) begin
                tick_cnt_r <= 32'h0;
                sec_r <= sec_r + 32'h1;
            end else begin
                tick_cnt_r <= tick_cnt_r + 32'h1;
            end
        end
    end
    // ------------------------------------------------------------
    // Per alarm time filter and notification hold-off
    // ------------------------------------------------------------
    reg [`ALT_NUM_ALM-1:0] act_r;   // Filtered active state
    reg [`ALT_NUM_ALM-1:0] pend_r;  // Notification awaiting release
    wire [`ALT_NUM_ALM-1:0] pend_ready;
    genvar g;
    generate
        for (g = 0; g < `ALT_NUM_ALM; g = g + 1) begin : alm
            reg [4:0] tf_cnt_r;
            reg [6:0] nf_cnt_r;
            // Active only once defect has lasted longer than setting
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tf_cnt_r <= 5'h0;
                    act_r[g] <= 1'b0;
                end else if (clk_en) begin
                    if (!raw[g]) begin
                        tf_cnt_r <= 5'h0;
                        act_r[g] <= 1'b0;
                    end else if (tick_r) begin
                        if (tf_cnt_r > {1'b0, tf_set}) begin
                            act_r[g] <= 1'b1;
                        end else begin
                            tf_cnt_r <= tf_cnt_r + 5'h1;
                        end
                    end
                end
            end
            // Hold-off counter since first unreported state change
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    nf_cnt_r <= 7'h0;
                end else if (clk_en) begin
                    if (pend_r[g] == 1'b0) begin
                        nf_cnt_r <= 7'h0;
                    end else if (tick_r && nf_cnt_r < nf_sec) begin
                        nf_cnt_r <= nf_cnt_r + 7'h1;
                    end
                end
            end
            assign pend_ready[g] = pend_r[g] && (nf_cnt_r >= nf_sec);
        end
    endgenerate
    // ------------------------------------------------------------
    // Notification selection: lowest pending alarm wins
    // ------------------------------------------------------------
    reg [`ALT_NUM_ALM-1:0] rep_r;   // State last reported
    reg [`ALT_NUM_ALM-1:0] evt_sticky_r;
    reg [4:0] sel_idx;
    reg sel_hit;
    integer i;
    always @* begin
        sel_idx = 5'h0;
        sel_hit = 1'b0;
        for (i = `ALT_NUM_ALM - 1; i >= 0; i = i - 1) begin
            if (pend_ready[i] && nmsk_r[i]) begin
                sel_idx = i[4:0];
                sel_hit = 1'b1;
            end
        end
    end
    wire [`ALT_NUM_ALM-1:0] changed = act_r ^ rep_r;
    wire [2:0] sel_sev = act_r[sel_idx] ? sev_of(sel_idx) :
        `ALT_SEV_CLEARED;
    // Pending severity is swallowed, not sent
    wire sel_send = sel_hit && (sel_sev != `ALT_SEV_PEND);
    // Record: time[39:16], type[15:13], sev[12:10], cause[9:5], fn[4:0]
    wire [2:0] sel_type = (sel_idx < 5'd12) ? 3'h1 :
        (sel_idx < 5'd17) ? 3'h2 : 3'h3;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= {`ALT_NUM_ALM{1'b0}};
            rep_r <= {`ALT_NUM_ALM{1'b0}};
            evt_valid <= 1'b0;
            evt_data <= {`ALT_EVT_W{1'b0}};
        end else if (clk_en) begin
            evt_valid <= 1'b0;
            // Change arms the hold-off; release clears it
            pend_r <= (pend_r | changed) & nmsk_r;
            if (sel_hit) begin
                pend_r[sel_idx] <= 1'b0;
                rep_r[sel_idx] <= act_r[sel_idx];
                if (sel_send) begin
                    evt_valid <= 1'b1;
                    evt_data <= {sec_r[23:0], sel_type, sel_sev,
                        (sel_idx < 5'd10) ? 5'h0 : sel_idx - 5'd9,
                        sel_idx};
                end
            end
            // Unselected alarms update silently
            rep_r <= (rep_r & nmsk_r) | (act_r & ~nmsk_r);
            if (sel_hit) begin
                rep_r[sel_idx] <= act_r[sel_idx];
            end
        end
    end
    // ------------------------------------------------------------
    // APB register file and test controls
    // ------------------------------------------------------------
    reg [NPORT-1:0] eoc_r;
    reg [NCH-1:0] saved_r;
    reg [UNIT_W-1:0] cause_r;
    wire wr = psel && penable && pwrite;
    wire rd_ok = (paddr[1:0] == 2'b00) && (paddr <= `ALT_REG_CAUSE);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !rd_ok;
    // Latest event sticky and unit capture; set wins over clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_sticky_r <= {`ALT_NUM_ALM{1'b0}};
            cause_r <= {UNIT_W{1'b0}};
        end else if (clk_en) begin
            if (raw[`ALT_A_XC] && !act_r[`ALT_A_XC]) begin
                cause_r <= sync2_r[NRAW-1:32];
            end
            evt_sticky_r <= ((wr && paddr == `ALT_REG_EVT) ?
                evt_sticky_r & ~pwdata[`ALT_NUM_ALM-1:0] : evt_sticky_r)
                | (act_r & ~rep_r);
        end
    end
    // Control writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 32'h0;
            filt_r <= 32'h0;
            nmsk_r <= {`ALT_NUM_ALM{1'b1}};
            eoc_r <= {NPORT{1'b0}};
            remote_line_loopback <= {NPORT{1'b0}};
            local_line_loopback <= {NPORT{1'b0}};
            drop_active <= 1'b0;
            drop_split <= 1'b0;
            drop_chans <= {NCH{1'b0}};
            drop_ports <= {NPORT{1'b0}};
            chan_loopback <= {NCH{1'b0}};
            saved_r <= {NCH{1'b0}};
            xc_restore <= {NCH{1'b0}};
            xc_restore_stb <= 1'b0;
        end else if (clk_en) begin
            xc_restore_stb <= 1'b0;
            if (wr) begin
                case (paddr)
                    `ALT_REG_CTRL: ctrl_r <= pwdata;
                    `ALT_REG_FILT: filt_r <= pwdata;
                    `ALT_REG_NMSK: nmsk_r <= pwdata[`ALT_NUM_ALM-1:0];
                    `ALT_REG_EOC: begin
                        eoc_r <= pwdata[NPORT-1:0];
                        // Drop loops that now carry the channel
                        remote_line_loopback <= remote_line_loopback &
                            ~pwdata[NPORT-1:0];
                        local_line_loopback <= local_line_loopback &
                            ~pwdata[NPORT-1:0];
                    end
                    `ALT_REG_LLB: remote_line_loopback <=
                        pwdata[NPORT-1:0] & ~eoc_r;
                    `ALT_REG_LLBL: local_line_loopback <=
                        pwdata[NPORT-1:0] & ~eoc_r &
                        {NPORT{ctrl_r[1]}};
                    `ALT_REG_DPORT: drop_ports <= pwdata[NPORT-1:0];
                    `ALT_REG_CLB: chan_loopback <= pwdata[NCH-1:0];
                    `ALT_REG_DROP: begin
                        if (pwdata[0] && !drop_active &&
                            pwdata[NCH-1:1] != {(NCH-1){1'b0}}) begin
                            // Start: save the selected channels for restore
                            drop_active <= 1'b1;
                            drop_split <= pwdata[1] & 1'b0 | ctrl_r[2];
                            drop_chans <= {pwdata[NCH-1:1], 1'b0};
                            saved_r <= {pwdata[NCH-1:1], 1'b0};
                        end else if (!pwdata[0] && drop_active) begin
                            drop_active <= 1'b0;
                            drop_split <= 1'b0;
                            drop_chans <= {NCH{1'b0}};
                            xc_restore <= saved_r;
                            xc_restore_stb <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
    // Split breaks the connection, monitoring keeps it
    // The matrix acts on drop_split while drop_active is high.
    // Read mux, whole loopback picture visible at once
    always @* begin
        case (paddr)
            `ALT_REG_CTRL: prdata = ctrl_r;
            `ALT_REG_FILT: prdata = filt_r;
            `ALT_REG_NMSK: prdata = {6'h00, nmsk_r};
            `ALT_REG_RAW: prdata = {6'h00, raw};
            `ALT_REG_ACT: prdata = {6'h00, act_r};
            `ALT_REG_EVT: prdata = {6'h00, evt_sticky_r};
            `ALT_REG_LLB: prdata = {{(32-NPORT){1'b0}},
                remote_line_loopback};
            `ALT_REG_LLBL: prdata = {{(32-NPORT){1'b0}},
                local_line_loopback};
            `ALT_REG_EOC: prdata = {{(32-NPORT){1'b0}}, eoc_r};
            `ALT_REG_DROP: prdata = drop_chans | {30'h0, drop_split,
                drop_active};
            `ALT_REG_DPORT: prdata = {{(32-NPORT){1'b0}}, drop_ports};
            `ALT_REG_CLB: prdata = chan_loopback;
            `ALT_REG_TEST: prdata = sec_r;
            `ALT_REG_SAVED: prdata = saved_r;
            `ALT_REG_CAUSE: prdata = {{(32-UNIT_W){1'b0}}, cause_r};
            default: prdata = 32'h0;
        endcase
    end
endmodule
`default_nettype wire

// >>> verif/alt_ctrl_checker.sv
// Port checks for the alarm and loopback control block
`timescale 1ns/1ps
`default_nettype none
`include "alt_defs.vh"
module alt_ctrl_checker #(parameter NPORT = 8) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Defect pin and notifications
    input wire logic u_los,
    input wire logic evt_valid,
    input wire logic [`ALT_EVT_W-1:0] evt_data,
    // Test controls
    input wire logic [NPORT-1:0] remote_line_loopback,
    input wire logic drop_active,
    input wire logic xc_restore_stb
);
    // ----------------------------------------------------------
    // Checks
    // ----------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable; // Access phase
    // Access beyond the last register
    sequence s_bad; acc && paddr > `ALT_REG_CAUSE; endsequence
    // Raise of the unstructured signal loss alarm
    sequence s_rise;
        evt_valid && evt_data[4:0] == 5'h00 && evt_data[12:10] != 3'h0;
    endsequence
    // Drop test being torn down
    sequence s_end; $fell(drop_active); endsequence
    AST_READY: assert property (acc |-> pready)
        else $error("pready low in access");
    AST_UNMAPPED: assert property (s_bad |-> pslverr)
        else $error("no error on unmapped access");
    AST_BAD_NOEFFECT: assert property
        (s_bad and pwrite |=> $stable(remote_line_loopback))
        else $error("refused write changed loopbacks");
    AST_FREEZE: assert property
        (!clk_en |=> $stable(remote_line_loopback))
        else $error("loopbacks moved while frozen");
    AST_PULSE: assert property (evt_valid |=> !evt_valid)
        else $error("notification longer than a cycle");
    AST_NO_PEND: assert property
        (evt_valid |-> evt_data[12:10] != `ALT_SEV_PEND)
        else $error("pending severity notified");
    AST_TYPE: assert property
        (evt_valid |-> evt_data[15:13] inside {3'h1, 3'h2, 3'h3})
        else $error("bad alarm type");
    AST_FILTER: assert property (s_rise |-> $past(u_los, 3))
        else $error("alarm raised before filtering");
    AST_RESTORE: assert property (s_end |-> ##[0:2] xc_restore_stb)
        else $error("no restore after drop");
endmodule
bind alt_ctrl alt_ctrl_checker #(.NPORT(NPORT)) chk_u (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .u_los(u_los), .evt_valid(evt_valid), .evt_data(evt_data),
    .remote_line_loopback(remote_line_loopback),
    .drop_active(drop_active), .xc_restore_stb(xc_restore_stb));
`default_nettype wire

// >>> verif/alt_mgmt_sink.sv
// Management-side sink that logs alarm notifications
`timescale 1ns/1ps
`default_nettype none
module alt_mgmt_sink (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Notification stream
    input wire logic evt_valid,
    input wire logic [39:0] evt_data,
    // Log summary
    output var logic [15:0] evt_cnt,
    output var logic [39:0] evt_last
);
    // ----------------------------------------------------------
    // Log
    // ----------------------------------------------------------
    // Raise and clear both land here, so the bench sees each one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_cnt <= 16'h0000;
            evt_last <= 40'h0000000000;
        end else if (evt_valid) begin
            evt_cnt <= evt_cnt + 16'h0001;
            evt_last <= evt_data;
        end
    end
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the alarm and loopback control block
`timescale 1ns/1ps
`default_nettype none
`include "alt_defs.vh"
module testbench;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
    logic pwrite = 0, pready, pslverr, evt_valid, xc_restore_stb, se;
    logic drop_active, drop_split;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd, v, dchans, clb, xcr;
    logic [39:0] d = 40'h0000000000, evt_data, evt_last; // Defect pins
    logic [7:0] rll, lll, dports;
    logic [15:0] evt_cnt;
    integer error_cnt = 0, samples_checked = 0, seed = 1749, i, k, n;
    int exq[$]; // Expected severities in order
    always #25 pclk = ~pclk;
    alt_ctrl #(.TICK_CYC(10)) dut_u (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .s_los(d[0]), .s_lof(d[1]), .s_exber(d[2]),
        .s_slot0_rdi(d[3]), .s_ais(d[4]), .s_signalling_lmfa(d[5]),
        .s_signalling_rdi(d[6]), .s_signalling_ais(d[7]), .u_los(d[8]),
        .u_bpv(d[9]), .sync_loss(d[10]), .mgmt_link_fail(d[11]),
        .port_fault(d[16:12]), .ext_pwr_absent(d[17]), .psu_fault(d[18]),
        .conn_fail(d[19]), .conn_fail_unit(d[27:20]),
        .primary_timing_reference_loss(d[28]),
        .secondary_timing_reference_loss(d[29]),
        .secondary_required(d[30]), .cl_fault(d[34:31]),
        .proc_fault(d[39:35]), .evt_valid(evt_valid), .evt_data(evt_data),
        .remote_line_loopback(rll), .local_line_loopback(lll),
        .drop_active(drop_active), .drop_split(drop_split),
        .drop_chans(dchans), .drop_ports(dports), .chan_loopback(clb),
        .xc_restore(xcr), .xc_restore_stb(xc_restore_stb));
    alt_mgmt_sink sink_u (.pclk(pclk), .presetn(presetn),
        .evt_valid(evt_valid), .evt_data(evt_data), .evt_cnt(evt_cnt),
        .evt_last(evt_last));
    // ----------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------
    // Compare and count
    task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; read data and error taken at the ready edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] x);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= x;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
        @(negedge pclk);
    endtask
    // Wait a bounded time for the next notification
    task wev;
        logic [15:0] c;
        c = evt_cnt;
        for (k = 0; k < 300 && evt_cnt === c; k++) @(negedge pclk);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Hang guard, well past the planned run
    initial begin
        #2000000;
        error_cnt++;
        report_and_stop;
    end
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        apb(0, `ALT_REG_LLB, 0); chk("llb reset", 0, rd);
        // Loopbacks on ports carrying the EOC are refused
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            apb(1, `ALT_REG_EOC, i * 3);
            apb(1, `ALT_REG_LLB, v);
            n = v & ~(i * 3) & 8'hFF;
            apb(0, `ALT_REG_LLB, 0); chk("llb", n, rd);
            chk("rll pins", n, rll);
        end
        apb(1, 12'h03C, 32'hFFFFFFFF); chk("slverr", 1, se);
        clk_en <= 0; // Frozen: the write is not taken
        apb(1, `ALT_REG_LLB, ~n);
        clk_en <= 1;
        apb(0, `ALT_REG_LLB, 0); chk("llb kept", n, rd);
        v = $random(seed);
        apb(1, `ALT_REG_CLB, v); chk("chan loop", v, clb);
        apb(1, `ALT_REG_CLB, 0); chk("chan off", 0, clb);
        // Monitor drop with one channel, split drop with all 31
        for (i = 0; i < 2; i++) begin
            apb(1, `ALT_REG_CTRL, i << 2);
            apb(1, `ALT_REG_DPORT, 32'h00000005);
            apb(1, `ALT_REG_DROP, i ? 32'hFFFFFFFF : 32'h00000003);
            chk("drop on", 1, drop_active);
            chk("split", i, drop_split);
            chk("dports", 5, dports);
            chk("chans", i ? 32'hFFFFFFFE : 2, dchans);
            apb(1, `ALT_REG_DROP, 0);
            chk("drop off", 0, drop_active);
            chk("restore", i ? 32'hFFFFFFFE : 2, xcr);
        end
        // Signal loss alarm raised after filtering, then cleared
        apb(1, `ALT_REG_CTRL, 0);
        apb(1, `ALT_REG_FILT, 32'h00000001);
        d[8] <= 1;
        exq.push_back(3);
        wev;
        chk("alarm idx", 0, evt_last[4:0]);
        chk("sev", 40'(exq.pop_front()), evt_last[12:10]);
        apb(0, `ALT_REG_ACT, 0); chk("act", 1, rd[0]);
        d[8] <= 0;
        exq.push_back(0);
        wev;
        chk("clear", 40'(exq.pop_front()), evt_last[12:10]);
        // Unselected alarms stay silent under random defects
        apb(1, `ALT_REG_NMSK, 0);
        n = evt_cnt;
        for (i = 0; i < 40; i++) begin
            @(posedge pclk);
            v = $random(seed);
            d <= {v[7:0], v};
        end
        d <= 40'h0000000000;
        repeat (30) @(posedge pclk);
        chk("silent", n, evt_cnt);
        report_and_stop;
    end
endmodule
`default_nettype wire
